// ### common/mode_ctrl_defines.vh
// Constants for the system mode controller: states, field codes, timing.
// Assumes a 250 MHz clock on clk; included by its bare name.
`ifndef MODE_CTRL_DEFINES_VH
`define MODE_CTRL_DEFINES_VH
// ==========================================================
// Mode states, one-hot
`define ST_INIT      7'h01
`define ST_NORMAL    7'h02
`define ST_STOP      7'h04
`define ST_SLEEP     7'h08
`define ST_RESTART   7'h10
`define ST_FAILSAFE  7'h20
`define ST_DEV       7'h40
// ==========================================================
// Software mode requests
`define REQ_NORMAL   3'h0
`define REQ_SLEEP    3'h1
`define REQ_STOP     3'h2
`define REQ_SWRESET  3'h3
// ==========================================================
// Transceiver modes
`define TRX_OFF      2'h0
`define TRX_WAKE     2'h1
`define TRX_RXONLY   2'h2
`define TRX_NORMAL   2'h3
// ==========================================================
// Status field codes
`define DEV_CLEARED  2'h0
`define DEV_RESTART  2'h1
`define DEV_WAKE     2'h2
`define WDF_NONE     2'h0
`define RESET_LIMIT  2'h3
// ==========================================================
// Timing, printed units then cycles at 250 MHz
`define CLK_MHZ            250
`define RESET_DELAY_US     10
`define THERMAL_HOLD_MS    1000
`define FAILSAFE_HOLD_MS   100
`define US_CYCLES          250
`define MS_CYCLES          250000
`define TMR_10MS   3'h0
`define TMR_20MS   3'h1
`define TMR_50MS   3'h2
`define TMR_100MS  3'h3
`define TMR_200MS  3'h4
`define TMR_1S     3'h5
`define TMR_2S     3'h6
// Period lengths in milliseconds
`define LEN_10MS   11'h00A
`define LEN_20MS   11'h014
`define LEN_50MS   11'h032
`define LEN_100MS  11'h064
`define LEN_200MS  11'h0C8
`define LEN_1S     11'h3E8
`define LEN_2S     11'h7D0
// ==========================================================
// Idle levels of the synchronised pins, test pin pulled up
`define PIN_IDLE   10'h200
`endif

// ### hdl/system_mode_controller.v
// Mode state machine of a supply and transceiver companion chip.
// Assumes fault and wake inputs from analog monitors, command strobes from
// the serial port decoder, and a single 250 MHz clock.
//
// How it works
// - Sleep turns main rail off; wake goes via Restart to Normal, source recorded.
// - Sleep entry forces Normal or Receive-Only transceivers to wake capable.
// - In Sleep serial commands are ignored and no response is given.
// - Sleep request with wake flags set wakes at once via Restart.
// - Reset output drops as soon as a Sleep command is accepted.
// - Restart on undervoltage, enabled overvoltage, watchdog fail, or wake.
// - Status field reads 01 for fault restart, 10 for Sleep wake.
// - Watchdog field kept for watchdog cause, 00 for wake; fault flags set.
// - With reset limit set, no watchdog reset after three in a row.
// - Restart exits to Normal after cause clears and reset delay elapses.
// - Restart entry or exit and Fail-Safe exit keep fail outputs.
// - Restart drops aux rail, holds reset low, ignores serial, shows status.
// - Restart makes active transceivers wake capable, others off.
// - Overvoltage reset is off after reset until software enables it.
// - Overtemp or rail short enters Fail-Safe: rails off, fail outputs on.
// - Fail-Safe held 1 s after overtemp, 100 ms else; wakes latched.
// - Latched or later wake leaves Fail-Safe for Restart.
// - Fail-Safe makes transceivers wake capable, wake pin only after the hold, cyclic wake off.
// - Fail-Safe return shows 01 and overtemp or short and undervoltage.
// - Development entry needs test pin low in Init, blocked after soft reset.
// - Development ignores watchdog fails; ends by soft reset, Sleep, or a supply or thermal fault.
// - Enabled periodic timer pulses an interrupt at the end of each period in Normal and Stop.
// - Any command in Init moves to Normal, or to Development if allowed and test pin low.
// - Stop to Sleep request sets serial fail flag and restarts.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"
module system_mode_controller #(
  parameter RESET_DELAY_CYC = `RESET_DELAY_US * `US_CYCLES,
  parameter THERMAL_CYC     = `THERMAL_HOLD_MS * `MS_CYCLES,
  parameter FAILSAFE_CYC    = `FAILSAFE_HOLD_MS * `MS_CYCLES,
  parameter MS_CYC          = `MS_CYCLES
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       cmd_valid,
  input  wire [2:0] cmd_mode,
  input  wire       cmd_is_mode,
  input  wire       overvoltage_reset_enable,
  input  wire       reset_limit_enable,
  input  wire [2:0] periodic_timer_config,
  input  wire       timer_wake_enable,
  input  wire [1:0] can_mode_cfg,
  input  wire [1:0] lin_mode_cfg,
  input  wire       aux_rail_cfg,
  input  wire       failout_test_pin,
  input  wire       main_rail_uv,
  input  wire       main_rail_ov,
  input  wire       main_rail_short,
  input  wire       overtemp_shutdown_event,
  input  wire       watchdog_fail,
  input  wire [1:0] watchdog_fail_count,
  input  wire       can_wake,
  input  wire       lin_wake,
  input  wire       wake_input_pin,
  input  wire       wake_status_clear,
  output reg  [6:0] mode_q,
  output reg        main_supply_rail_q,
  output reg        aux_supply_rail_q,
  output reg        reset_output_q,
  output reg        failsafe_outputs_q,
  output reg  [1:0] can_mode_q,
  output reg  [1:0] lin_mode_q,
  output reg        wake_input_enable_q,
  output reg        cyclic_wake_enable_q,
  output reg  [1:0] device_status_field_q,
  output reg  [1:0] watchdog_fail_field_q,
  output reg        main_rail_undervoltage_flag_q,
  output reg        main_rail_overvoltage_flag_q,
  output reg        main_rail_short_flag_q,
  output reg        overtemp_flag_q,
  output reg        spi_fail_flag_q,
  output reg  [2:0] wake_status_first_q,
  output wire       spi_accept,
  output reg        timer_irq_q
);

  // ==========================================================
  // Pin synchronisers
  reg  [9:0] sync1_q;
  reg  [9:0] sync2_q;
  wire [9:0] pins = {failout_test_pin, main_rail_uv, main_rail_ov, main_rail_short,
                     overtemp_shutdown_event, watchdog_fail, can_wake, lin_wake,
                     wake_input_pin, 1'b0};
  // Both stages reset to idle levels, so no false test pin level follows reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= `PIN_IDLE;
      sync2_q <= `PIN_IDLE;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end
  // Synchronised pin levels, only the second stage is read
  wire test_s  = sync2_q[9];
  wire uv_s    = sync2_q[8];
  wire ov_s    = sync2_q[7];
  wire sc_s    = sync2_q[6];
  wire tsd_s   = sync2_q[5];
  wire wdf_s   = sync2_q[4];
  wire [2:0] wake_s = sync2_q[3:1];
  wire wake_any = |wake_s;

  // Transceiver mode after Restart or Sleep entry
  function [1:0] to_wake;
    input [1:0] m;
    begin
      to_wake = (m == `TRX_OFF) ? `TRX_OFF : `TRX_WAKE;
    end
  endfunction

  // Period select in milliseconds, ascending code
  function [10:0] period_ms;
    input [2:0] c;
    begin
      case (c)
        `TMR_10MS:  period_ms = `LEN_10MS;
        `TMR_20MS:  period_ms = `LEN_20MS;
        `TMR_50MS:  period_ms = `LEN_50MS;
        `TMR_100MS: period_ms = `LEN_100MS;
        `TMR_200MS: period_ms = `LEN_200MS;
        `TMR_1S:    period_ms = `LEN_1S;
        default:    period_ms = `LEN_2S;
      endcase
    end
  endfunction

  // ==========================================================
  // Mode state machine
  // Hold timer, wake latch, soft reset block and watchdog restart count
  reg  [31:0] hold_q;
  reg         wake_latch_q;
  reg         dev_block_q;
  reg  [1:0]  wd_reset_cnt_q;
  wire in_restart = mode_q == `ST_RESTART;
  wire in_fs      = mode_q == `ST_FAILSAFE;
  wire run_mode   = (mode_q == `ST_NORMAL) | (mode_q == `ST_STOP);
  // Serial port answers only outside Sleep, Restart and Fail-Safe
  assign spi_accept = ~(mode_q == `ST_SLEEP) & ~in_restart & ~in_fs;
  wire cmd = cmd_valid & spi_accept;
  // Restart and fail-safe causes
  wire ov_rst = ov_s & overvoltage_reset_enable;
  wire wd_rst = wdf_s & ~(reset_limit_enable & (wd_reset_cnt_q == `RESET_LIMIT));
  wire fault_fs = tsd_s | sc_s;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q                        <= `ST_INIT;
      main_supply_rail_q            <= 1'b1;
      aux_supply_rail_q             <= 1'b0;
      reset_output_q                <= 1'b0;
      failsafe_outputs_q            <= 1'b0;
      can_mode_q                    <= `TRX_OFF;
      lin_mode_q                    <= `TRX_OFF;
      wake_input_enable_q           <= 1'b0;
      cyclic_wake_enable_q          <= 1'b0;
      device_status_field_q         <= `DEV_CLEARED;
      watchdog_fail_field_q         <= `WDF_NONE;
      main_rail_undervoltage_flag_q <= 1'b0;
      main_rail_overvoltage_flag_q  <= 1'b0;
      main_rail_short_flag_q        <= 1'b0;
      overtemp_flag_q               <= 1'b0;
      spi_fail_flag_q               <= 1'b0;
      wake_status_first_q           <= 3'h0;
      hold_q                        <= 32'h0;
      wake_latch_q                  <= 1'b0;
      dev_block_q                   <= 1'b0;
      wd_reset_cnt_q                <= 2'h0;
    end else begin
      // Wake flags: set wins over clear
      if (wake_status_clear)
        wake_status_first_q <= wake_s;
      else
        wake_status_first_q <= wake_status_first_q | wake_s;
      // Hold timer runs down to zero; the branches below reload it
      if (hold_q != 32'h0)
        hold_q <= hold_q - 32'h1;
      case (mode_q)
        `ST_INIT: begin
          // Any command leaves Init
          if (cmd) begin
            reset_output_q <= 1'b1;
            if (!test_s && !dev_block_q)
              mode_q <= `ST_DEV;
            else
              mode_q <= `ST_NORMAL;
          end
        end
        `ST_NORMAL, `ST_STOP, `ST_DEV: begin
          // Follow the configuration while running
          can_mode_q        <= can_mode_cfg;
          lin_mode_q        <= lin_mode_cfg;
          aux_supply_rail_q <= aux_rail_cfg;
          wake_input_enable_q  <= 1'b1;
          cyclic_wake_enable_q <= timer_wake_enable;
          // Faults first, then restart causes, then host requests
          if (fault_fs) begin
            mode_q                 <= `ST_FAILSAFE;
            main_supply_rail_q     <= 1'b0;
            aux_supply_rail_q      <= 1'b0;
            reset_output_q         <= 1'b0;
            failsafe_outputs_q     <= 1'b1;
            overtemp_flag_q        <= tsd_s;
            main_rail_short_flag_q <= sc_s;
            main_rail_undervoltage_flag_q <= sc_s | main_rail_undervoltage_flag_q;
            device_status_field_q  <= `DEV_RESTART;
            wake_latch_q           <= 1'b0;
            hold_q <= tsd_s ? THERMAL_CYC : FAILSAFE_CYC;
          end else if (uv_s || ov_rst || (wd_rst && mode_q != `ST_DEV)) begin
            mode_q                 <= `ST_RESTART;
            reset_output_q         <= 1'b0;
            device_status_field_q  <= `DEV_RESTART;
            aux_supply_rail_q      <= 1'b0;
            can_mode_q             <= to_wake(can_mode_cfg);
            lin_mode_q             <= to_wake(lin_mode_cfg);
            main_rail_undervoltage_flag_q <= uv_s;
            main_rail_overvoltage_flag_q  <= ov_rst & ~uv_s;
            // Watchdog cause recorded only when no supply cause is present
            if (wdf_s && !uv_s && !ov_rst) begin
              watchdog_fail_field_q <= watchdog_fail_count;
              if (wd_reset_cnt_q != `RESET_LIMIT)         // Saturates, never wraps
                wd_reset_cnt_q <= wd_reset_cnt_q + 2'h1;
            end
            hold_q <= RESET_DELAY_CYC;
          end else if (cmd && cmd_is_mode) begin
            // Mode requests from the host
            if (cmd_mode == `REQ_SWRESET) begin
              mode_q         <= `ST_INIT;
              dev_block_q    <= 1'b1;
              reset_output_q <= 1'b0;
              hold_q         <= RESET_DELAY_CYC;
            end else if (cmd_mode == `REQ_SLEEP && mode_q == `ST_STOP) begin
              spi_fail_flag_q <= 1'b1;
              mode_q          <= `ST_RESTART;
              reset_output_q  <= 1'b0;
              aux_supply_rail_q <= 1'b0;
              can_mode_q      <= to_wake(can_mode_cfg);
              lin_mode_q      <= to_wake(lin_mode_cfg);
              device_status_field_q <= `DEV_RESTART;
              hold_q          <= RESET_DELAY_CYC;
            end else if (cmd_mode == `REQ_SLEEP) begin
              reset_output_q <= 1'b0;
              if (wake_status_first_q != 3'h0 || wake_any) begin
                mode_q <= `ST_RESTART;
                device_status_field_q <= `DEV_WAKE;
                aux_supply_rail_q <= 1'b0;
                can_mode_q <= to_wake(can_mode_cfg);
                lin_mode_q <= to_wake(lin_mode_cfg);
                hold_q <= RESET_DELAY_CYC;
              end else begin
                mode_q             <= `ST_SLEEP;
                main_supply_rail_q <= 1'b0;
                // Active transceivers stay behind as wake sources
                can_mode_q <= to_wake(can_mode_cfg);
                lin_mode_q <= to_wake(lin_mode_cfg);
              end
            end else if (cmd_mode == `REQ_STOP && mode_q != `ST_DEV) begin
              mode_q <= `ST_STOP;
            end else if (cmd_mode == `REQ_NORMAL && mode_q != `ST_DEV) begin
              mode_q <= `ST_NORMAL;
            end
          end
        end
        `ST_SLEEP: begin
          // Only a wake leaves Sleep
          if (wake_any) begin
            mode_q                <= `ST_RESTART;
            main_supply_rail_q    <= 1'b1;
            aux_supply_rail_q     <= 1'b0;
            device_status_field_q <= `DEV_WAKE;
            watchdog_fail_field_q <= `WDF_NONE;
            wd_reset_cnt_q        <= 2'h0;
            hold_q                <= RESET_DELAY_CYC;
          end
        end
        `ST_RESTART: begin
          // Reset held low until the cause clears and the delay runs out
          main_supply_rail_q <= 1'b1;
          aux_supply_rail_q  <= 1'b0;
          reset_output_q     <= 1'b0;
          can_mode_q <= to_wake(can_mode_q);
          lin_mode_q <= to_wake(lin_mode_q);
          // A supply cause still present restarts the delay
          if (uv_s || ov_rst)
            hold_q <= RESET_DELAY_CYC;
          else if (hold_q == 32'h0) begin
            mode_q         <= `ST_NORMAL;
            reset_output_q <= 1'b1;
          end
        end
        `ST_FAILSAFE: begin
          // Wakes latched during the hold, acted on once it expires
          can_mode_q           <= `TRX_WAKE;
          lin_mode_q           <= `TRX_WAKE;
          cyclic_wake_enable_q <= 1'b0;
          wake_input_enable_q  <= (hold_q == 32'h0);
          if (wake_any)
            wake_latch_q <= 1'b1;
          if (hold_q == 32'h0 && (wake_latch_q || wake_any)) begin
            mode_q             <= `ST_RESTART;
            main_supply_rail_q <= 1'b1;
            wake_latch_q       <= 1'b0;
            hold_q             <= RESET_DELAY_CYC;
          end
        end
        default: mode_q <= `ST_INIT;
      endcase
    end
  end

  // ==========================================================
  // Periodic wake timer, pulse at end of each period
  reg [17:0] ms_cnt_q;
  reg [10:0] per_cnt_q;
  // Millisecond prescaler feeds the period counter
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_q    <= 18'h0;
      per_cnt_q   <= 11'h0;
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= 1'b0;
      // Counters idle outside Normal and Stop or while disabled
      if (!(timer_wake_enable && run_mode)) begin
        ms_cnt_q  <= 18'h0;
        per_cnt_q <= 11'h0;
      end else if (ms_cnt_q == MS_CYC[17:0] - 18'h1) begin
        ms_cnt_q <= 18'h0;
        if (per_cnt_q == period_ms(periodic_timer_config) - 11'h1) begin
          per_cnt_q   <= 11'h0;
          timer_irq_q <= 1'b1;
        end else
          per_cnt_q <= per_cnt_q + 11'h1;
      end else
        ms_cnt_q <= ms_cnt_q + 18'h1;
    end
  end
endmodule

// ### verification/mode_checker.sv
// Checker of mode outputs against commands and the current mode.
// Assumes binding to system_mode_controller; sees its ports only.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"
module mode_checker (
  input logic       clk,
  input logic       reset_n,
  input logic       cmd_valid,
  input logic [2:0] cmd_mode,
  input logic       cmd_is_mode,
  input logic       spi_accept,
  input logic [6:0] mode_q,
  input logic       main_supply_rail_q,
  input logic       aux_supply_rail_q,
  input logic       reset_output_q,
  input logic       failsafe_outputs_q,
  input logic [1:0] can_mode_q,
  input logic [1:0] lin_mode_q,
  input logic       wake_input_enable_q,
  input logic       cyclic_wake_enable_q
);
  // ==========================================================
  // Mode relations
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire low_pwr = mode_q == `ST_SLEEP || mode_q == `ST_RESTART || mode_q == `ST_FAILSAFE;
  sequence in_restart; mode_q == `ST_RESTART; endsequence
  sequence to_normal; mode_q == `ST_NORMAL; endsequence
  sequence sleep_taken;
    cmd_valid && cmd_is_mode && cmd_mode == `REQ_SLEEP && spi_accept && mode_q == `ST_NORMAL;
  endsequence
  sleep_outputs_a: assert property ($past(mode_q) == `ST_SLEEP && mode_q == `ST_SLEEP
    |-> !main_supply_rail_q && !reset_output_q) else $error("sleep outputs wrong");
  sleep_trx_a: assert property ($past(mode_q) == `ST_SLEEP && mode_q == `ST_SLEEP
    |-> can_mode_q < `TRX_RXONLY && lin_mode_q < `TRX_RXONLY) else $error("sleep trx active");
  quiet_modes_a: assert property (low_pwr |-> !spi_accept)
    else $error("command taken in quiet mode");
  sleep_cmd_a: assert property (sleep_taken |=> !reset_output_q && mode_q != `ST_NORMAL)
    else $error("sleep command not obeyed");
  restart_hold_a: assert property (in_restart ##1 in_restart
    |-> !reset_output_q && !aux_supply_rail_q) else $error("restart outputs wrong");
  restart_exit_a: assert property (in_restart ##1 to_normal |-> reset_output_q)
    else $error("reset not released on exit");
  fail_keep_a: assert property (($past(mode_q) == `ST_RESTART || $past(mode_q) == `ST_FAILSAFE
    || mode_q == `ST_RESTART) && $past(failsafe_outputs_q) |-> failsafe_outputs_q)
    else $error("fail outputs dropped");
  failsafe_state_a: assert property ($past(mode_q) == `ST_FAILSAFE && mode_q == `ST_FAILSAFE
    |-> !main_supply_rail_q && !reset_output_q && failsafe_outputs_q && can_mode_q == `TRX_WAKE
    && lin_mode_q == `TRX_WAKE && !cyclic_wake_enable_q)
    else $error("fail-safe outputs wrong");
  fs_wake_mute_a: assert property (mode_q == `ST_FAILSAFE && $past(mode_q) != `ST_FAILSAFE
    |=> !wake_input_enable_q) else $error("wake sources live during hold");
  sleep_deaf_a: assert property (mode_q == `ST_SLEEP && cmd_valid
    |=> !reset_output_q && (mode_q == `ST_SLEEP || mode_q == `ST_RESTART))
    else $error("command answered in sleep");
  init_cmd_a: assert property (cmd_valid && spi_accept && mode_q == `ST_INIT
    && !(cmd_is_mode && cmd_mode == `REQ_SWRESET) |=> mode_q == `ST_NORMAL || mode_q == `ST_DEV)
    else $error("init command ignored");
endmodule
bind system_mode_controller mode_checker u_chk (.*);

// ### verification/host_mcu_model.sv
// Host microcontroller model that issues decoded serial commands.
// Assumes the bench calls issue from its main sequence.
`timescale 1ns/1ps
module host_mcu_model (
  input  wire       clk,
  input  wire       reset_output,
  output reg        cmd_valid,
  output reg  [2:0] cmd_mode,
  output reg        cmd_is_mode
);
  // ==========================================================
  // Command issue
  initial begin
    cmd_valid = 1'b0;
    cmd_mode = 3'h7;
    cmd_is_mode = 1'b0;
  end
  // One-cycle command; waits out reset unless told to send regardless
  task issue(input [2:0] m, input is_mode, input in_reset);
    integer w;
    begin
      w = 0;
      while (!in_reset && reset_output !== 1'b1 && w < 500) begin
        @(posedge clk);
        w = w + 1;
      end
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_mode <= m;
      cmd_is_mode <= is_mode;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_mode <= ~m; // Released field shows no stale value
    end
  endtask
endmodule

// ### verification/system_mode_controller_tb.sv
// Bench for the system mode controller with a host model.
// Assumes shortened hold counts set on the instance below.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"
module system_mode_controller_tb;
  // ==========================================================
  // Signals and instances
  localparam RD = 8, TH = 40, FS = 20, MS = 4;
  localparam [76:0] PER = {11'h7D0, 11'h3E8, 11'h0C8, 11'h064, 11'h032, 11'h014, 11'h00A};
  reg clk, reset_n, overvoltage_reset_enable, reset_limit_enable, timer_wake_enable;
  reg aux_rail_cfg, failout_test_pin, main_rail_uv, main_rail_ov, main_rail_short;
  reg overtemp_shutdown_event, watchdog_fail, can_wake, lin_wake, wake_input_pin;
  reg wake_status_clear;
  reg [2:0] periodic_timer_config;
  reg [1:0] can_mode_cfg, lin_mode_cfg, watchdog_fail_count;
  wire cmd_valid, cmd_is_mode, main_supply_rail_q, aux_supply_rail_q, reset_output_q;
  wire failsafe_outputs_q, wake_input_enable_q, cyclic_wake_enable_q, spi_accept, timer_irq_q;
  wire main_rail_undervoltage_flag_q, main_rail_overvoltage_flag_q, main_rail_short_flag_q;
  wire overtemp_flag_q, spi_fail_flag_q;
  wire [6:0] mode_q;
  wire [2:0] cmd_mode, wake_status_first_q;
  wire [1:0] can_mode_q, lin_mode_q, device_status_field_q, watchdog_fail_field_q;
  integer bad_count, tests_run, cyc, n, k, h;
  system_mode_controller #(.RESET_DELAY_CYC(RD), .THERMAL_CYC(TH), .FAILSAFE_CYC(FS),
    .MS_CYC(MS)) u_dut (.*);
  host_mcu_model u_mcu (.clk(clk), .reset_output(reset_output_q), .cmd_valid(cmd_valid),
    .cmd_mode(cmd_mode), .cmd_is_mode(cmd_is_mode));
  // Clock and hang limit
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      bad_count = bad_count + 1;
      conclude;
    end
  end
  // ==========================================================
  // Shared tasks
  task chk(input [63:0] what, input [7:0] exp, input [7:0] got);
    begin
      tests_run = tests_run + 1;
      if (exp !== got) begin
        bad_count = bad_count + 1;
        $display("unexpected %0s exp %h seen %h", what, exp, got);
      end
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task wait_mode(input [6:0] m);
    begin
      n = 0;
      while (mode_q !== m && n < 400) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      chk("mode", m, mode_q);
    end
  endtask
  task wait_irq;
    begin
      n = 0;
      do begin
        @(posedge clk);
        #1 n = n + 1;
      end while (timer_irq_q !== 1'b1 && n < 9000);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ==========================================================
  // Scenarios
  task sc_sleep;
    begin
      u_mcu.issue(`REQ_SLEEP, 1'b1, 1'b0);
      wait_mode(`ST_SLEEP);
      chk("rail", 0, {main_supply_rail_q, reset_output_q});
      chk("trx", {`TRX_WAKE, `TRX_WAKE}, {can_mode_q, lin_mode_q});
      u_mcu.issue(`REQ_NORMAL, 1'b1, 1'b1);
      #1 chk("quiet", {`ST_SLEEP, 1'b0}, {mode_q, spi_accept});
      @(posedge clk) wake_input_pin <= 1'b1;
      tick(4);
      wake_input_pin <= 1'b0;
      wait_mode(`ST_RESTART);
      chk("rst", {`TRX_WAKE, 2'h0}, {can_mode_q, aux_supply_rail_q, reset_output_q});
      wait_mode(`ST_NORMAL);
      chk("delay", 1, n >= RD - 1 && n <= RD + 4);
      chk("stat", {`DEV_WAKE, `WDF_NONE, 3'h1}, {device_status_field_q, watchdog_fail_field_q,
        wake_status_first_q});
      u_mcu.issue(`REQ_SLEEP, 1'b1, 1'b0);
      wait_mode(`ST_RESTART);
      wait_mode(`ST_NORMAL);
      @(posedge clk) wake_status_clear <= 1'b1;
      @(posedge clk) wake_status_clear <= 1'b0;
      tick(2);
      chk("clear", 0, wake_status_first_q);
    end
  endtask
  task sc_supply;
    begin
      chk("aux", 1, aux_supply_rail_q);
      @(posedge clk) main_rail_uv <= 1'b1;
      tick(6);
      main_rail_uv <= 1'b0;
      wait_mode(`ST_RESTART);
      wait_mode(`ST_NORMAL);
      chk("uv", {`DEV_RESTART, 1'b1}, {device_status_field_q, main_rail_undervoltage_flag_q});
      for (k = 0; k < 2; k = k + 1) begin
        @(posedge clk) overvoltage_reset_enable <= k[0];
        main_rail_ov <= 1'b1;
        tick(6);
        main_rail_ov <= 1'b0;
        #1 chk("ovrst", k ? `ST_RESTART : `ST_NORMAL, mode_q);
        wait_mode(`ST_NORMAL);
      end
      chk("ov", 1, main_rail_overvoltage_flag_q);
      @(posedge clk) reset_limit_enable <= 1'b1;
      watchdog_fail_count <= 2'h1;
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge clk) watchdog_fail <= 1'b1;
        tick(3);
        watchdog_fail <= 1'b0;
        tick(3);
        #1 chk("wdrst", k < 3 ? `ST_RESTART : `ST_NORMAL, mode_q);
        wait_mode(`ST_NORMAL);
        chk("wdf", {`DEV_RESTART, 2'h1}, {device_status_field_q, watchdog_fail_field_q});
      end
      u_mcu.issue(`REQ_STOP, 1'b1, 1'b0);
      wait_mode(`ST_STOP);
      u_mcu.issue(`REQ_SLEEP, 1'b1, 1'b0);
      wait_mode(`ST_RESTART);
      chk("spif", 1, spi_fail_flag_q);
      wait_mode(`ST_NORMAL);
    end
  endtask
  task sc_fail(input ot);
    begin
      h = ot ? TH : FS;
      @(posedge clk) overtemp_shutdown_event <= ot;
      main_rail_short <= !ot;
      wait_mode(`ST_FAILSAFE);
      @(posedge clk) can_wake <= 1'b1;
      overtemp_shutdown_event <= 1'b0;
      main_rail_short <= 1'b0;
      tick(4);
      can_wake <= 1'b0;
      wait_mode(`ST_RESTART);
      chk("hold", 1, n + 5 >= h && n + 5 <= h + 6);
      wait_mode(`ST_NORMAL);
      chk("fsret", {`DEV_RESTART, 1'b1, 1'b1}, {device_status_field_q, failsafe_outputs_q,
        ot ? overtemp_flag_q : main_rail_short_flag_q & main_rail_undervoltage_flag_q});
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {cyc, bad_count, tests_run} = 96'h0;
    {overvoltage_reset_enable, reset_limit_enable, timer_wake_enable, aux_rail_cfg} = 4'h0;
    {main_rail_uv, main_rail_ov, main_rail_short, overtemp_shutdown_event} = 4'h0;
    {watchdog_fail, can_wake, lin_wake, wake_input_pin, wake_status_clear, reset_n} = 6'h00;
    {periodic_timer_config, can_mode_cfg, lin_mode_cfg, watchdog_fail_count} = 9'h0F8;
    failout_test_pin = 1'b1;
    tick(10);
    reset_n <= 1'b1;
    aux_rail_cfg <= 1'b1;
    #1 chk("init", {`ST_INIT, 1'b0}, {mode_q, reset_output_q});
    u_mcu.issue(`REQ_NORMAL, 1'b0, 1'b0);
    wait_mode(`ST_NORMAL);
    sc_sleep;
    sc_supply;
    for (k = 0; k < 7; k = k + 1) begin
      @(posedge clk) periodic_timer_config <= k[2:0];
      timer_wake_enable <= 1'b1;
      wait_irq;
      wait_irq;
      chk("period", 1, n == PER[k * 11 +: 11] * MS);
    end
    timer_wake_enable <= 1'b0;
    sc_fail(1'b1);
    sc_fail(1'b0);
    @(posedge clk) failout_test_pin <= 1'b0;
    reset_n <= 1'b0;
    tick(10);
    reset_n <= 1'b1;
    u_mcu.issue(`REQ_NORMAL, 1'b0, 1'b0);
    wait_mode(`ST_DEV);
    @(posedge clk) watchdog_fail <= 1'b1;
    tick(3);
    watchdog_fail <= 1'b0;
    tick(6);
    #1 chk("devwd", `ST_DEV, mode_q);
    u_mcu.issue(`REQ_SWRESET, 1'b1, 1'b0);
    wait_mode(`ST_INIT);
    u_mcu.issue(`REQ_NORMAL, 1'b0, 1'b0);
    wait_mode(`ST_NORMAL);
    conclude;
  end
endmodule
